// [rtl/rsfs_sequencer.sv]
// Start-up, soft-start and fault sequencer of a resonant converter with APB registers
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module rsfs_sequencer #(
	parameter int unsigned AVG_SHORT_CYCLES = rsfs_pkg::AVG_SHORT_CYC,
	parameter int unsigned AVG_LONG_CYCLES = rsfs_pkg::AVG_LONG_CYC,
	parameter int unsigned LIGHT_LOAD_CYCLES = rsfs_pkg::LIGHT_LOAD_CYC,
	parameter int unsigned WAKEUP_CYCLES = rsfs_pkg::WAKEUP_CYC,
	parameter int unsigned FAULT_PAUSE_CYCLES = rsfs_pkg::FAULT_PAUSE_CYC,
	parameter int unsigned BOOT_CHARGE_CYCLES = rsfs_pkg::BOOT_CHARGE_CYC,
	parameter int unsigned XCAP_SILENCE_CYCLES = rsfs_pkg::XCAP_SILENCE_CYC,
	parameter int unsigned XCAP_HOLD_CYCLES = rsfs_pkg::XCAP_HOLD_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [rsfs_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_output_overvoltage_fault,
	input wire logic i_over_temperature_fault,
	input wire logic i_peak_current_fault,
	input wire logic i_avg_current_fault_short,
	input wire logic i_avg_current_fault_long,
	input wire logic i_bulk_above_start,
	input wire logic i_bulk_below_stop,
	input wire logic i_bulk_overvoltage_fault,
	input wire logic i_regulated_supply_undervoltage,
	input wire logic i_supply_below_restart,
	input wire logic i_supply_above_switch_threshold,
	input wire logic i_mains_zero_cross_seen,
	input wire logic i_feedback_below_burst_level,
	input wire logic i_trim_load_done,
	input wire logic i_feedback_copy_below_softstart,
	input wire logic i_zero_current_switching_region,
	output logic o_waveform_generator_enable,
	output logic o_regulated_supply_enable,
	output logic o_supply_clamp_enable,
	output logic o_soft_start_enable,
	output logic o_filter_cap_discharge,
	output logic o_startup_switch_on,
	output logic o_low_side_gate,
	output logic o_feedback_from_rail,
	output logic o_pin_burst_threshold_mode,
	output logic o_softstart_pin_pulldown,
	output logic o_burst_mode_enable,
	output logic o_external_bias_select
);
	localparam int W = rsfs_pkg::CNT_W;
	localparam logic [W-1:0] WAKE_LAST = W'(WAKEUP_CYCLES - 1);
	localparam logic [W-1:0] BOOT_LAST = W'(BOOT_CHARGE_CYCLES - 1);
	localparam logic [W-1:0] PAUSE_LAST = W'(FAULT_PAUSE_CYCLES - 1);
	localparam logic [W-1:0] XCAP_ON = W'(XCAP_SILENCE_CYCLES);
	localparam logic [W-1:0] XCAP_END = W'(XCAP_SILENCE_CYCLES + XCAP_HOLD_CYCLES);

	logic [rsfs_pkg::IN_W-1:0] raw, sync1, sync2;
	rsfs_pkg::rsfs_state_t state, next_state;
	logic [W-1:0] state_cnt, next_state_cnt, xcap_cnt, next_xcap_cnt;
	logic ss_done, next_ss_done;
	logic avg_short_exp, avg_long_exp, light_exp, light_level;
	logic bulk_ok, fault_any;
	logic [rsfs_pkg::FAULT_W-1:0] cause, fault, next_fault;
	logic [rsfs_pkg::CTRL_W-1:0] ctrl, next_ctrl;
	logic restart_req, next_restart_req;
	logic wr_en, next_pready, next_pslverr;
	logic [31:0] next_prdata;
	logic next_wg, next_rvcc, next_clamp, next_ss_en, next_xcap, next_fet, next_lo;
	logic next_pulldown, next_burst, run_like;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	// ==========================================
	// Input synchroniser
	assign raw = {i_zero_current_switching_region, i_feedback_copy_below_softstart,
		i_trim_load_done, i_feedback_below_burst_level, i_mains_zero_cross_seen,
		i_supply_above_switch_threshold, i_supply_below_restart,
		i_regulated_supply_undervoltage, i_bulk_overvoltage_fault, i_bulk_below_stop,
		i_bulk_above_start, i_avg_current_fault_long, i_avg_current_fault_short,
		i_peak_current_fault, i_over_temperature_fault, i_output_overvoltage_fault};

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	// ==========================================
	// Fault qualification
	rsfs_qual_timer #(.CNT_W(W), .LIMIT(AVG_SHORT_CYCLES)) u_avg_short (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_level(sync2[rsfs_pkg::IN_AVG_SHORT]),
		.o_expired(avg_short_exp)
	);
	rsfs_qual_timer #(.CNT_W(W), .LIMIT(AVG_LONG_CYCLES)) u_avg_long (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_level(sync2[rsfs_pkg::IN_AVG_LONG]),
		.o_expired(avg_long_exp)
	);
	assign light_level = (state == rsfs_pkg::ST_LIGHT_LOAD) && sync2[rsfs_pkg::IN_FB_BELOW];
	rsfs_qual_timer #(.CNT_W(W), .LIMIT(LIGHT_LOAD_CYCLES)) u_light (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_level(light_level),
		.o_expired(light_exp)
	);

	always_comb
	begin
		cause = '0;
		cause[rsfs_pkg::F_OVP] = sync2[rsfs_pkg::IN_OVP];
		cause[rsfs_pkg::F_OTP] = sync2[rsfs_pkg::IN_OTP];
		cause[rsfs_pkg::F_PEAK] = sync2[rsfs_pkg::IN_PEAK];
		cause[rsfs_pkg::F_AVG_SHORT] = avg_short_exp;
		cause[rsfs_pkg::F_AVG_LONG] = avg_long_exp;
		cause[rsfs_pkg::F_BLK_OV] = sync2[rsfs_pkg::IN_BLK_OV];
		cause[rsfs_pkg::F_BLK_STOP] = sync2[rsfs_pkg::IN_BLK_STOP];
		cause[rsfs_pkg::F_UVLO] = sync2[rsfs_pkg::IN_UVLO];
		cause[rsfs_pkg::F_LIGHT] = light_exp;
	end
	assign fault_any = |cause;
	assign bulk_ok = sync2[rsfs_pkg::IN_BLK_START] && !sync2[rsfs_pkg::IN_BLK_STOP]
		&& !sync2[rsfs_pkg::IN_BLK_OV] && !sync2[rsfs_pkg::IN_UVLO];

	// ==========================================
	// State machine and outputs
	always_comb
	begin
		next_state = state;
		case (state)
			rsfs_pkg::ST_STARTUP:
				if (sync2[rsfs_pkg::IN_TRIM])
					next_state = rsfs_pkg::ST_CHARGING;
			rsfs_pkg::ST_CHARGING:
				if (sync2[rsfs_pkg::IN_SWITCH] && !sync2[rsfs_pkg::IN_RESTART])
					next_state = rsfs_pkg::ST_SWITCH_OFF;
			rsfs_pkg::ST_SWITCH_OFF:
				if (sync2[rsfs_pkg::IN_OTP] || sync2[rsfs_pkg::IN_BLK_OV])
					next_state = rsfs_pkg::ST_FAULT;
				else if (sync2[rsfs_pkg::IN_RESTART])
					next_state = rsfs_pkg::ST_CHARGING;
				else if (bulk_ok)
					next_state = rsfs_pkg::ST_WAKEUP;
			rsfs_pkg::ST_WAKEUP, rsfs_pkg::ST_BOOT_CHARGE:
				if (sync2[rsfs_pkg::IN_OTP] || sync2[rsfs_pkg::IN_BLK_OV])
					next_state = rsfs_pkg::ST_FAULT;
				else if (sync2[rsfs_pkg::IN_RESTART])
					next_state = rsfs_pkg::ST_CHARGING;
				else if (state == rsfs_pkg::ST_WAKEUP)
				begin
					// Waits out the wake-up time, then needs bulk still good
					if (state_cnt >= WAKE_LAST && bulk_ok
						&& !sync2[rsfs_pkg::IN_FB_BELOW])
						next_state = rsfs_pkg::ST_BOOT_CHARGE;
				end
				else if (state_cnt == BOOT_LAST)
					next_state = rsfs_pkg::ST_RUN;
			rsfs_pkg::ST_RUN, rsfs_pkg::ST_LIGHT_LOAD:
				if (fault_any)
					next_state = rsfs_pkg::ST_FAULT;
				else if (sync2[rsfs_pkg::IN_RESTART])
					next_state = rsfs_pkg::ST_CHARGING;
				else if (state == rsfs_pkg::ST_RUN)
				begin
					// Burst decisions only make sense once soft start has released control
					if (ss_done && sync2[rsfs_pkg::IN_FB_BELOW])
						next_state = rsfs_pkg::ST_LIGHT_LOAD;
				end
				else if (!sync2[rsfs_pkg::IN_FB_BELOW])
					next_state = rsfs_pkg::ST_RUN;
			rsfs_pkg::ST_FAULT:
				if (ctrl[rsfs_pkg::CTRL_LATCH])
					next_state = rsfs_pkg::ST_LATCH;
				else if (state_cnt == PAUSE_LAST)
					next_state = rsfs_pkg::ST_CHARGING;
			rsfs_pkg::ST_LATCH:
				if (restart_req)
					next_state = rsfs_pkg::ST_CHARGING;
			default:
				next_state = rsfs_pkg::ST_FAULT;
		endcase

		next_state_cnt = (next_state != state) ? '0 :
			(state_cnt == {W{1'b1}}) ? state_cnt : state_cnt + 1'b1;

		run_like = (next_state == rsfs_pkg::ST_RUN) || (next_state == rsfs_pkg::ST_LIGHT_LOAD);
		next_ss_done = ss_done;
		if (!run_like)
			next_ss_done = 1'b0;
		else if (state == rsfs_pkg::ST_RUN && sync2[rsfs_pkg::IN_SS_CMP])
			next_ss_done = 1'b1;

		next_wg = run_like;
		next_ss_en = run_like;
		next_rvcc = run_like || next_state == rsfs_pkg::ST_SWITCH_OFF
			|| next_state == rsfs_pkg::ST_WAKEUP || next_state == rsfs_pkg::ST_BOOT_CHARGE;
		next_clamp = next_state == rsfs_pkg::ST_STARTUP;
		next_fet = next_state == rsfs_pkg::ST_STARTUP
			|| next_state == rsfs_pkg::ST_CHARGING;
		next_lo = next_state == rsfs_pkg::ST_BOOT_CHARGE;
		next_pulldown = run_like && sync2[rsfs_pkg::IN_ZCS];
		next_burst = next_state == rsfs_pkg::ST_LIGHT_LOAD;

		// Discharge runs off mains silence alone, whatever the sequencer state
		next_xcap_cnt = sync2[rsfs_pkg::IN_ZERO_CROSS] ? '0 :
			(xcap_cnt == XCAP_END) ? xcap_cnt : xcap_cnt + 1'b1;
		next_xcap = next_xcap_cnt >= XCAP_ON && next_xcap_cnt < XCAP_END;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			state <= rsfs_pkg::ST_STARTUP;
			state_cnt <= '0;
			xcap_cnt <= '0;
			ss_done <= 1'b0;
			o_waveform_generator_enable <= 1'b0;
			o_regulated_supply_enable <= 1'b0;
			o_supply_clamp_enable <= 1'b1;
			o_soft_start_enable <= 1'b0;
			o_filter_cap_discharge <= 1'b0;
			o_startup_switch_on <= 1'b1;
			o_low_side_gate <= 1'b0;
			o_feedback_from_rail <= 1'b0;
			o_pin_burst_threshold_mode <= 1'b0;
			o_softstart_pin_pulldown <= 1'b0;
			o_burst_mode_enable <= 1'b0;
		end
		else
		begin
			state <= next_state;
			state_cnt <= next_state_cnt;
			xcap_cnt <= next_xcap_cnt;
			ss_done <= next_ss_done;
			o_waveform_generator_enable <= next_wg;
			o_regulated_supply_enable <= next_rvcc;
			o_supply_clamp_enable <= next_clamp;
			o_soft_start_enable <= next_ss_en;
			o_filter_cap_discharge <= next_xcap;
			o_startup_switch_on <= next_fet;
			o_low_side_gate <= next_lo;
			o_feedback_from_rail <= next_ss_done;
			o_pin_burst_threshold_mode <= next_ss_done;
			o_softstart_pin_pulldown <= next_pulldown;
			o_burst_mode_enable <= next_burst;
		end
	end

	// ==========================================
	// APB slave, zero wait states: pready rises in the access cycle
	assign wr_en = i_psel && i_penable && o_pready && i_pwrite;

	always_comb
	begin
		next_pready = i_psel && !i_penable;
		next_pslverr = 1'b0;
		next_prdata = '0;
		case (i_paddr)
			rsfs_pkg::REG_CTRL:
				next_prdata[rsfs_pkg::CTRL_W-1:0] = ctrl;
			rsfs_pkg::REG_STATUS:
			begin
				next_prdata[rsfs_pkg::STAT_STATE_LSB +: rsfs_pkg::STAT_STATE_W] = state;
				next_prdata[rsfs_pkg::STAT_SS_DONE] = ss_done;
				next_prdata[rsfs_pkg::STAT_BURST] = o_burst_mode_enable;
				next_prdata[rsfs_pkg::STAT_XCAP] = o_filter_cap_discharge;
			end
			rsfs_pkg::REG_FAULT:
				next_prdata[rsfs_pkg::FAULT_W-1:0] = fault;
			default:
				next_pslverr = i_psel && !i_penable;
		endcase
		next_ctrl = ctrl;
		next_restart_req = 1'b0;
		next_fault = fault;
		if (wr_en && i_paddr == rsfs_pkg::REG_CTRL)
		begin
			next_ctrl = i_pwdata[rsfs_pkg::CTRL_W-1:0];
			next_restart_req = i_pwdata[rsfs_pkg::CTRL_RESTART];
		end
		if (wr_en && i_paddr == rsfs_pkg::REG_FAULT)
			next_fault = fault & ~i_pwdata[rsfs_pkg::FAULT_W-1:0];
		// A cause seen on the way into the fault state beats a clear in the same cycle
		if (next_state == rsfs_pkg::ST_FAULT && state != rsfs_pkg::ST_FAULT)
			next_fault = next_fault | cause;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_prdata <= '0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			ctrl <= rsfs_pkg::CTRL_RESET;
			restart_req <= 1'b0;
			fault <= rsfs_pkg::FAULT_RESET;
			o_external_bias_select <= 1'b0;
		end
		else
		begin
			o_prdata <= next_prdata;
			o_pready <= next_pready;
			o_pslverr <= next_pslverr;
			ctrl <= next_ctrl;
			restart_req <= next_restart_req;
			fault <= next_fault;
			o_external_bias_select <= next_ctrl[rsfs_pkg::CTRL_EXT_BIAS];
		end
	end

	// ==========================================
	// Checks
	sequence s_boot_ends;
		state == rsfs_pkg::ST_BOOT_CHARGE ##1 state == rsfs_pkg::ST_RUN;
	endsequence
	sequence s_pause_ends;
		state == rsfs_pkg::ST_FAULT ##1 state == rsfs_pkg::ST_CHARGING;
	endsequence

	a_boot_then_soft: assert property (s_boot_ends |-> o_soft_start_enable
		&& o_waveform_generator_enable && !o_low_side_gate && $past(state_cnt) == BOOT_LAST)
		else $error("soft start did not follow a full boot precharge");
	a_soft_done_set: assert property (state == rsfs_pkg::ST_RUN
		&& next_state == rsfs_pkg::ST_RUN && sync2[rsfs_pkg::IN_SS_CMP] |=> ss_done)
		else $error("soft start not declared done on comparator");
	a_rail_after_soft: assert property ($rose(ss_done) |-> o_feedback_from_rail
		&& o_pin_burst_threshold_mode)
		else $error("feedback chain not switched to rail after soft start");
	a_zcs_pulldown: assert property (o_softstart_pin_pulldown |->
		$past(sync2[rsfs_pkg::IN_ZCS]) && o_waveform_generator_enable)
		else $error("pin pulldown without zero-current region");
	a_switch_off_move: assert property (state == rsfs_pkg::ST_CHARGING
		&& sync2[rsfs_pkg::IN_SWITCH] && !sync2[rsfs_pkg::IN_RESTART]
		|=> state == rsfs_pkg::ST_SWITCH_OFF && !o_startup_switch_on && o_regulated_supply_enable)
		else $error("start-up switch not turned off at threshold");
	a_bulk_gates_wake: assert property (state == rsfs_pkg::ST_SWITCH_OFF
		##1 state == rsfs_pkg::ST_WAKEUP |-> $past(bulk_ok))
		else $error("wake-up entered without bulk ready");
	a_boot_low_side: assert property (state == rsfs_pkg::ST_BOOT_CHARGE |->
		o_low_side_gate && !o_waveform_generator_enable)
		else $error("low-side gate not held during boot precharge");
	a_burst_in_light: assert property (state == rsfs_pkg::ST_LIGHT_LOAD |->
		o_burst_mode_enable && $past(ss_done))
		else $error("light-load state without burst mode");
	a_fault_stops_run: assert property (state == rsfs_pkg::ST_RUN && fault_any
		|=> state == rsfs_pkg::ST_FAULT ##0 !o_waveform_generator_enable)
		else $error("fault did not stop switching");
	a_fault_outputs_low: assert property (state == rsfs_pkg::ST_FAULT |->
		!(o_waveform_generator_enable || o_regulated_supply_enable || o_supply_clamp_enable
		|| o_soft_start_enable || o_startup_switch_on))
		else $error("outputs active in fault state");
	a_fault_pause_len: assert property (s_pause_ends |-> $past(state_cnt) == PAUSE_LAST)
		else $error("restart before the fault pause ended");
	a_wake_dwell: assert property (state == rsfs_pkg::ST_WAKEUP
		##1 state == rsfs_pkg::ST_BOOT_CHARGE |-> $past(state_cnt) >= WAKE_LAST)
		else $error("wake-up left before its dwell time");
	a_supply_restart: assert property (state == rsfs_pkg::ST_SWITCH_OFF
		&& sync2[rsfs_pkg::IN_RESTART] && !sync2[rsfs_pkg::IN_OTP]
		&& !sync2[rsfs_pkg::IN_BLK_OV] |=> state == rsfs_pkg::ST_CHARGING && o_startup_switch_on)
		else $error("supply restart did not reopen the start-up switch");
endmodule

// [rtl/rsfs_pkg.sv]
// Constants and types of the resonant start and fault sequencer
package rsfs_pkg;

	// ==========================================
	// Clock and timing
	localparam int CLK_HZ = 50_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1_000;
	localparam int AVG_SHORT_MS = 2;
	localparam int AVG_SHORT_CYC = AVG_SHORT_MS * CYC_PER_MS;
	localparam int AVG_LONG_MS = 50;
	localparam int AVG_LONG_CYC = AVG_LONG_MS * CYC_PER_MS;
	localparam int LIGHT_LOAD_MS = 200;
	localparam int LIGHT_LOAD_CYC = LIGHT_LOAD_MS * CYC_PER_MS;
	localparam int WAKEUP_US = 150;
	localparam int WAKEUP_CYC = WAKEUP_US * CYC_PER_US;
	localparam int FAULT_PAUSE_S = 1;
	localparam int FAULT_PAUSE_CYC = FAULT_PAUSE_S * CLK_HZ;
	localparam int BOOT_CHARGE_US = 20;
	localparam int BOOT_CHARGE_CYC = BOOT_CHARGE_US * CYC_PER_US;
	localparam int XCAP_SILENCE_MS = 2800;
	localparam int XCAP_SILENCE_CYC = XCAP_SILENCE_MS * CYC_PER_MS;
	localparam int XCAP_HOLD_MS = 350;
	localparam int XCAP_HOLD_CYC = XCAP_HOLD_MS * CYC_PER_MS;
	localparam int CNT_W = 28;

	// ==========================================
	// Register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FAULT = 8'h08;
	localparam int CTRL_EXT_BIAS = 0;
	localparam int CTRL_LATCH = 1;
	localparam int CTRL_RESTART = 2;
	localparam int CTRL_W = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_STATE_W = 4;
	localparam int STAT_SS_DONE = 4;
	localparam int STAT_BURST = 5;
	localparam int STAT_XCAP = 6;
	localparam int F_OVP = 0;
	localparam int F_OTP = 1;
	localparam int F_PEAK = 2;
	localparam int F_AVG_SHORT = 3;
	localparam int F_AVG_LONG = 4;
	localparam int F_BLK_OV = 5;
	localparam int F_BLK_STOP = 6;
	localparam int F_UVLO = 7;
	localparam int F_LIGHT = 8;
	localparam int FAULT_W = 9;
	localparam logic [8:0] FAULT_RESET = 9'h000;

	// ==========================================
	// Synchronised flag positions
	localparam int IN_OVP = 0;
	localparam int IN_OTP = 1;
	localparam int IN_PEAK = 2;
	localparam int IN_AVG_SHORT = 3;
	localparam int IN_AVG_LONG = 4;
	localparam int IN_BLK_START = 5;
	localparam int IN_BLK_STOP = 6;
	localparam int IN_BLK_OV = 7;
	localparam int IN_UVLO = 8;
	localparam int IN_RESTART = 9;
	localparam int IN_SWITCH = 10;
	localparam int IN_ZERO_CROSS = 11;
	localparam int IN_FB_BELOW = 12;
	localparam int IN_TRIM = 13;
	localparam int IN_SS_CMP = 14;
	localparam int IN_ZCS = 15;
	localparam int IN_W = 16;

	typedef enum logic [3:0] {
		ST_STARTUP,
		ST_CHARGING,
		ST_SWITCH_OFF,
		ST_WAKEUP,
		ST_BOOT_CHARGE,
		ST_RUN,
		ST_LIGHT_LOAD,
		ST_FAULT,
		ST_LATCH
	} rsfs_state_t;

endpackage

// [rtl/rsfs_qual_timer.sv]
// Qualification timer: flags a level that has stayed high for a set time
`timescale 1ns/1ps
module rsfs_qual_timer #(
	parameter int CNT_W = 28,
	parameter int unsigned LIMIT = 100000
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_level,
	output logic o_expired
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic next_expired;

	// ==========================================
	// Counter
	// Any drop of the level restarts the qualification from zero
	always_comb
	begin
		next_cnt = cnt;
		if (!i_level)
			next_cnt = '0;
		else if (cnt != LAST)
			next_cnt = cnt + 1'b1;
		next_expired = i_level && (cnt == LAST);
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			cnt <= '0;
			o_expired <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			o_expired <= next_expired;
		end
	end

	// ==========================================
	// Checks
	a_expire_after_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_expired) |-> $past(i_level) && $past(cnt) == LAST)
		else $error("timer expired before the full hold time");
	a_expire_drops_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!i_level |=> !o_expired)
		else $error("timer stayed expired after the level fell");
endmodule

// [verification/rsfs_analog_model.sv]
// Behavioural model of the supply rail, trim loader and soft-start comparator
`timescale 1ns/1ps
module rsfs_analog_model (
	input wire logic i_core_clk,
	input wire logic i_startup_switch_on,
	input wire logic i_soft_start_enable,
	output logic o_trim_load_done,
	output logic o_supply_above_switch_threshold,
	output logic o_feedback_copy_below_softstart
);
	// ==========================================
	// Rail charge and soft-start ramp
	int chg = 0;
	int ramp = 0;
	always @(posedge i_core_clk)
	begin
		chg <= i_startup_switch_on ? chg + 1 : chg;
		ramp <= i_soft_start_enable ? ramp + 1 : 0;
	end
	// Rail stays up once charged; the bias winding would hold it there
	assign o_trim_load_done = chg > 3;
	assign o_supply_above_switch_threshold = chg > 12;
	assign o_feedback_copy_below_softstart = ramp > 6;
endmodule

// [verification/rsfs_sequencer_tb_top.sv]
// Bench of the start and fault sequencer with its analog partner
`timescale 1ns/1ps
module rsfs_sequencer_tb_top;
	// ==========================================
	// Signals
	logic i_core_clk = 1'h0;
	logic i_rst = 1'h1;
	logic i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, zc_on = 1'h1;
	logic [7:0] i_paddr = 8'h00, flt = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, r;
	logic o_pready, o_pslverr, e, i_trim_load_done, i_supply_above_switch_threshold;
	logic i_bulk_above_start = 1'h0, i_supply_below_restart = 1'h0;
	logic i_mains_zero_cross_seen = 1'h0, i_feedback_below_burst_level = 1'h0;
	logic i_zero_current_switching_region = 1'h0, i_feedback_copy_below_softstart;
	logic o_waveform_generator_enable, o_regulated_supply_enable, o_supply_clamp_enable;
	logic o_soft_start_enable, o_filter_cap_discharge, o_startup_switch_on, o_low_side_gate;
	logic o_feedback_from_rail, o_pin_burst_threshold_mode, o_softstart_pin_pulldown;
	logic o_burst_mode_enable, o_external_bias_select;
	int err_total = 0, n_tests = 0, k, i;

	rsfs_sequencer #(.AVG_SHORT_CYCLES(20), .AVG_LONG_CYCLES(40), .LIGHT_LOAD_CYCLES(30),
		.WAKEUP_CYCLES(10), .FAULT_PAUSE_CYCLES(50), .BOOT_CHARGE_CYCLES(8),
		.XCAP_SILENCE_CYCLES(60), .XCAP_HOLD_CYCLES(20)) rsfs_sequencer_inst (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_psel(i_psel),
		.i_penable(i_penable),
		.i_pwrite(i_pwrite),
		.i_paddr(i_paddr),
		.i_pwdata(i_pwdata),
		.o_prdata(o_prdata),
		.o_pready(o_pready),
		.o_pslverr(o_pslverr),
		.i_bulk_above_start(i_bulk_above_start),
		.i_supply_below_restart(i_supply_below_restart),
		.i_supply_above_switch_threshold(i_supply_above_switch_threshold),
		.i_mains_zero_cross_seen(i_mains_zero_cross_seen),
		.i_feedback_below_burst_level(i_feedback_below_burst_level),
		.i_trim_load_done(i_trim_load_done),
		.i_feedback_copy_below_softstart(i_feedback_copy_below_softstart),
		.i_zero_current_switching_region(i_zero_current_switching_region),
		.o_waveform_generator_enable(o_waveform_generator_enable),
		.o_regulated_supply_enable(o_regulated_supply_enable),
		.o_supply_clamp_enable(o_supply_clamp_enable),
		.o_soft_start_enable(o_soft_start_enable),
		.o_filter_cap_discharge(o_filter_cap_discharge),
		.o_startup_switch_on(o_startup_switch_on),
		.o_low_side_gate(o_low_side_gate),
		.o_feedback_from_rail(o_feedback_from_rail),
		.o_pin_burst_threshold_mode(o_pin_burst_threshold_mode),
		.o_softstart_pin_pulldown(o_softstart_pin_pulldown),
		.o_burst_mode_enable(o_burst_mode_enable),
		.o_external_bias_select(o_external_bias_select),
		.i_output_overvoltage_fault(flt[0]),
		.i_over_temperature_fault(flt[1]),
		.i_peak_current_fault(flt[2]),
		.i_avg_current_fault_short(flt[3]),
		.i_avg_current_fault_long(flt[4]),
		.i_bulk_overvoltage_fault(flt[5]),
		.i_bulk_below_stop(flt[6]),
		.i_regulated_supply_undervoltage(flt[7])
	);
	rsfs_analog_model rsfs_analog_model_inst (
		.i_core_clk(i_core_clk),
		.i_startup_switch_on(o_startup_switch_on),
		.i_soft_start_enable(o_soft_start_enable),
		.o_trim_load_done(i_trim_load_done),
		.o_supply_above_switch_threshold(i_supply_above_switch_threshold),
		.o_feedback_copy_below_softstart(i_feedback_copy_below_softstart)
	);

	initial
	begin
		forever #10 i_core_clk = ~i_core_clk;
	end
	// Mains present: a crossing seen every other cycle
	always @(posedge i_core_clk)
		i_mains_zero_cross_seen <= zc_on & ~i_mains_zero_cross_seen;

	// ==========================================
	// Tasks
	task automatic end_sim;
		if (err_total == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'h1;
		for (k = 0; k < 20 && o_pready !== 1'h1; k++)
			@(posedge i_core_clk);
		r = o_prdata;
		e = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		if (k == 20)
		begin
			err_total++;
			end_sim();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(r & m, x);
	endtask
	task automatic wait_st(input logic [3:0] s);
		int n;
		for (n = 0; n < 400; n++)
		begin
			apb(1'h0, 8'h04, 32'h0);
			if (r[3:0] === s)
				break;
		end
		chk(r[3:0], s);
		if (n == 400)
			end_sim();
	endtask

	// ==========================================
	// Sequence
	initial
	begin
		repeat (8) @(posedge i_core_clk);
		chk({o_supply_clamp_enable, o_startup_switch_on, o_regulated_supply_enable}, 32'h6);
		i_rst <= 1'h0;
		rd(8'h00, 32'hffffffff, 32'h0);
		apb(1'h0, 8'h40, 32'h0);
		chk({r[30:0], e}, 32'h1);
		wait_st(4'h2);
		chk({o_startup_switch_on, o_regulated_supply_enable}, 32'h1);
		i_supply_below_restart <= 1'h1;
		wait_st(4'h1);
		chk(o_startup_switch_on, 32'h1);
		i_supply_below_restart <= 1'h0;
		wait_st(4'h2);
		apb(1'h1, 8'h00, 32'h1);
		// Select output moves at the commit edge; look one edge later
		@(posedge i_core_clk);
		chk(o_external_bias_select, 32'h1);
		apb(1'h1, 8'h00, 32'h0);
		@(posedge i_core_clk);
		chk(o_external_bias_select, 32'h0);
		i_bulk_above_start <= 1'h1;
		for (k = 0; k < 500 && o_low_side_gate !== 1'h1; k++)
			@(posedge i_core_clk);
		chk(k >= 10, 32'h1);
		for (k = 0; k < 100 && o_low_side_gate === 1'h1; k++)
			@(posedge i_core_clk);
		chk(k, 32'h8);
		chk({o_waveform_generator_enable, o_soft_start_enable, o_feedback_from_rail}, 32'h6);
		repeat (20) @(posedge i_core_clk);
		rd(8'h04, 32'h1f, 32'h15);
		chk({o_feedback_from_rail, o_pin_burst_threshold_mode}, 32'h3);
		i_zero_current_switching_region <= 1'h1;
		repeat (4) @(posedge i_core_clk);
		chk(o_softstart_pin_pulldown, 32'h1);
		i_zero_current_switching_region <= 1'h0;
		i_feedback_below_burst_level <= 1'h1;
		repeat (5) @(posedge i_core_clk);
		chk(o_burst_mode_enable, 32'h1);
		wait_st(4'h7);
		rd(8'h08, 32'h1ff, 32'h100);
		chk({o_waveform_generator_enable, o_regulated_supply_enable, o_supply_clamp_enable,
			o_soft_start_enable, o_startup_switch_on}, 32'h0);
		i_feedback_below_burst_level <= 1'h0;
		apb(1'h1, 8'h08, 32'h1ff);
		for (i = 0; i < 8; i++)
		begin
			wait_st(4'h5);
			flt <= 8'h01 << i;
			if (i == 3 || i == 4)
			begin
				repeat (12) @(posedge i_core_clk);
				rd(8'h04, 32'hf, 32'h5);
			end
			wait_st(4'h7);
			rd(8'h08, 32'h1ff, 32'h1 << i);
			flt <= 8'h00;
			apb(1'h1, 8'h08, 32'h1ff);
		end
		wait_st(4'h5);
		apb(1'h1, 8'h00, 32'h2);
		flt <= 8'h02;
		// Latch mode leaves the fault state after one cycle, too short to poll
		wait_st(4'h8);
		rd(8'h08, 32'h1ff, 32'h2);
		flt <= 8'h00;
		repeat (60) @(posedge i_core_clk);
		rd(8'h04, 32'hf, 32'h8);
		apb(1'h1, 8'h00, 32'h4);
		wait_st(4'h5);
		i_supply_below_restart <= 1'h1;
		wait_st(4'h1);
		chk(o_startup_switch_on, 32'h1);
		i_supply_below_restart <= 1'h0;
		zc_on <= 1'h0;
		for (k = 0; k < 200 && o_filter_cap_discharge !== 1'h1; k++)
			@(posedge i_core_clk);
		for (k = 0; k < 100 && o_filter_cap_discharge === 1'h1; k++)
			@(posedge i_core_clk);
		chk(k, 32'h14);
		end_sim();
	end
endmodule
